/* File: rtl/hsmws_pkg.sv */
/*
 * hsmws_pkg: constants shared by the hall sensor measurement sequencer.
 * assumes a 200 MHz system clock and a separate i2c link clock domain.
 */
package hsmws_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned DATA_W = 12;
  // analogue settle times in nanoseconds, rounded up to whole cycles
  localparam int unsigned BIAS_NS = 50;
  localparam int unsigned OSC_NS = 40;
  localparam int unsigned HALL_NS = 60;
  localparam int unsigned BIAS_CYC = (BIAS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OSC_CYC = (OSC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HALL_CYC = (HALL_NS * CLK_MHZ + 999) / 1000;
  // interrupt pulse length in internal clock cycles
  localparam int unsigned INT_PULSE_CYC = 8;
  localparam int unsigned CNT_W = 8;
  localparam logic [1:0] CH_X = 2'h0;
  localparam logic [1:0] CH_Y = 2'h1;
  localparam logic [1:0] CH_Z = 2'h2;
  localparam logic [1:0] CH_T = 2'h3;
  localparam logic TEMP_EN_RST = 1'b1;

  typedef enum logic [2:0] {
    HSMWS_LOWPWR, HSMWS_BIAS, HSMWS_CHECK, HSMWS_OSC,
    HSMWS_HALL, HSMWS_CONV, HSMWS_DONE
  } hsmws_state_t;
endpackage

/* File: rtl/hsmws_top.sv */
/*
 * hsmws_top: measurement sequencer and wake-up comparator.
 * assumes an external i2c slave supplies config pulses and bus activity on
 * the link clock; the converter answers each start with a done pulse.
 */
// Overview of operation
// R1: start-up enables bias, oscillator, then low power
// R2: reconfigure runs bias, check, osc, hall, convert
// R3: low supply halts sequencer, restarts from beginning
// R4: restart event aborts and restarts current function
// R5: convert x, y, z in order via mux
// R6: temperature optional, on after reset, last
// R7: upper and lower threshold per axis compared
// R8: out-of-window component pulses interrupt output
// R9: all inside window gives no interrupt
// R10: collision avoidance suppresses interrupt during i2c
// R11: interrupt is or of three axis results
// R12: open-drain interrupt marks finished measurement cycle
// R13: sensor acts only as i2c slave
// R14: master issues i2c reset after power-up
// R15: converter inhibited until supply adequate
// R16: active-low interrupt pulse of fixed length
`timescale 1ns/1ps
module hsmws_top
  import hsmws_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_cfg_wr,
  input wire logic link_busy,
  input wire logic temp_en,
  input wire logic coll_avoid_en,
  input wire logic supply_ok,
  input wire logic [DATA_W-1:0] thr_hi_x,
  input wire logic [DATA_W-1:0] thr_hi_y,
  input wire logic [DATA_W-1:0] thr_hi_z,
  input wire logic [DATA_W-1:0] thr_lo_x,
  input wire logic [DATA_W-1:0] thr_lo_y,
  input wire logic [DATA_W-1:0] thr_lo_z,
  input wire logic adc_done,
  input wire logic [DATA_W-1:0] adc_data,
  output logic bias_en,
  output logic osc_en,
  output logic hall_bias_en,
  output logic adc_start,
  output logic [1:0] mux_sel,
  output logic [DATA_W-1:0] result_x,
  output logic [DATA_W-1:0] result_y,
  output logic [DATA_W-1:0] result_z,
  output logic [DATA_W-1:0] result_t,
  output logic cycle_busy,
  output logic int_n_o,
  output logic int_n_oe
);
  logic rst_s1_q, rst_n;
  logic lrst_s1_q, lrst_n_q;
  logic [DATA_W-1:0] thr_hi_x_q, thr_hi_y_q, thr_hi_z_q;
  logic [DATA_W-1:0] thr_lo_x_q, thr_lo_y_q, thr_lo_z_q;
  logic tog_q, tog_s1_q, tog_s2_q, tog_s3_q;
  logic busy_s1_q, busy_s2_q;
  logic sup_s1_q, sup_s2_q, sup_ok_q;
  logic done_s1_q, done_s2_q, done_d3_q;
  logic temp_s1_q, temp_s2_q, ca_s1_q, ca_s2_q;
  logic cfg_pend_q, cfg_evt, done_evt, restart;
  hsmws_state_t state_q;
  logic [CNT_W-1:0] wait_q;
  logic [1:0] ch_q;
  logic conv_q;
  logic [2:0] oow_q;
  logic wake_q, wake_pend_q;
  logic [CNT_W-1:0] pulse_q;
  logic oow_now;

  // reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // link side reset, released on link_clk so the toggle flop never sees
  // a release racing its own clock edge
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      lrst_s1_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_n_q <= lrst_s1_q;
    end
  end

  // link side: config write becomes a toggle, crossed as an event
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) tog_q <= 1'b0;
    else if (link_cfg_wr) tog_q <= ~tog_q;
  end

  // config toggle: two sync flops, a third keeps the old value for the edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // bus activity level from the link side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= link_busy;
      busy_s2_q <= busy_s1_q;
    end
  end

  // supply level; the third flop marks the first good cycle after a dip
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_s1_q <= 1'b0;
      sup_s2_q <= 1'b0;
      sup_ok_q <= 1'b0;
    end else begin
      sup_s1_q <= supply_ok;
      sup_s2_q <= sup_s1_q;
      sup_ok_q <= sup_s2_q;
    end
  end

  // converter done: synced, then delayed once to find its rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_d3_q <= 1'b0;
    end else begin
      done_s1_q <= adc_done;
      done_s2_q <= done_s1_q;
      done_d3_q <= done_s2_q;
    end
  end

  // static mode levels; temperature conversion is on out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_s1_q <= TEMP_EN_RST;
      temp_s2_q <= TEMP_EN_RST;
      ca_s1_q <= 1'b0;
      ca_s2_q <= 1'b0;
    end else begin
      temp_s1_q <= temp_en;
      temp_s2_q <= temp_s1_q;
      ca_s1_q <= coll_avoid_en;
      ca_s2_q <= ca_s1_q;
    end
  end

  assign cfg_evt = tog_s2_q ^ tog_s3_q;
  assign done_evt = done_s2_q & ~done_d3_q;
  // a supply dip, new or in progress, abandons the running function
  assign restart = ~sup_s2_q | (sup_s2_q & ~sup_ok_q); // R3 R4

  // a config arriving mid-cycle is remembered, not dropped; one that finds
  // the sequencer idle starts it at once and is consumed at that edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cfg_pend_q <= 1'b0;
    else if (state_q == HSMWS_LOWPWR && sup_s2_q) cfg_pend_q <= 1'b0;
    else if (cfg_evt) cfg_pend_q <= 1'b1;
  end

  // thresholds cross from the link side as a bundle, sampled only on the
  // synchronised config event while the writer holds them steady; a config
  // landing mid-cycle may judge the later axes against the new values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_hi_x_q <= '0;
      thr_hi_y_q <= '0;
      thr_hi_z_q <= '0;
      thr_lo_x_q <= '0;
      thr_lo_y_q <= '0;
      thr_lo_z_q <= '0;
    end else if (cfg_evt) begin
      thr_hi_x_q <= thr_hi_x;
      thr_hi_y_q <= thr_hi_y;
      thr_hi_z_q <= thr_hi_z;
      thr_lo_x_q <= thr_lo_x;
      thr_lo_y_q <= thr_lo_y;
      thr_lo_z_q <= thr_lo_z;
    end
  end

  // measurement sequencer; only ever reacts, never masters the bus
  always_ff @(posedge clk or negedge rst_n) begin // R13
    if (!rst_n) begin
      state_q <= HSMWS_LOWPWR; // R1
      wait_q <= '0;
      ch_q <= CH_X;
      conv_q <= 1'b0;
    end else if (restart && state_q != HSMWS_LOWPWR) begin
      state_q <= HSMWS_BIAS; // R3 R4
      wait_q <= CNT_W'(BIAS_CYC);
      ch_q <= CH_X;
      conv_q <= 1'b0;
    end else begin
      unique case (state_q)
        HSMWS_LOWPWR: begin
          if ((cfg_evt || cfg_pend_q) && sup_s2_q) begin
            state_q <= HSMWS_BIAS; // R2
            wait_q <= CNT_W'(BIAS_CYC);
          end
        end
        HSMWS_BIAS: begin
          if (wait_q != '0) wait_q <= wait_q - 1'b1;
          else state_q <= HSMWS_CHECK;
        end
        HSMWS_CHECK: begin
          // hold here until supply good enough for conversion
          if (sup_ok_q) begin // R15
            state_q <= HSMWS_OSC;
            wait_q <= CNT_W'(OSC_CYC);
          end
        end
        HSMWS_OSC: begin
          if (wait_q != '0) wait_q <= wait_q - 1'b1;
          else begin
            state_q <= HSMWS_HALL;
            wait_q <= CNT_W'(HALL_CYC);
          end
        end
        HSMWS_HALL: begin
          if (wait_q != '0) wait_q <= wait_q - 1'b1;
          else begin
            state_q <= HSMWS_CONV;
            ch_q <= CH_X;
            conv_q <= 1'b0;
          end
        end
        HSMWS_CONV: begin
          if (!conv_q) conv_q <= 1'b1;
          else if (done_evt) begin
            conv_q <= 1'b0;
            // x then y then z, temperature last when enabled
            if (ch_q == CH_Z && !temp_s2_q) state_q <= HSMWS_DONE; // R5 R6
            else if (ch_q == CH_T) state_q <= HSMWS_DONE; // R6
            else ch_q <= ch_q + 2'h1; // R5
          end
        end
        HSMWS_DONE: state_q <= HSMWS_LOWPWR; // R2
        default: state_q <= HSMWS_LOWPWR;
      endcase
    end
  end

  // analogue enables and converter start, registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_en <= 1'b1; // R1
      osc_en <= 1'b1; // R1
      hall_bias_en <= 1'b0;
      adc_start <= 1'b0;
      mux_sel <= CH_X;
      cycle_busy <= 1'b0;
    end else begin
      bias_en <= state_q != HSMWS_LOWPWR; // R2
      osc_en <= state_q inside {HSMWS_OSC, HSMWS_HALL, HSMWS_CONV};
      hall_bias_en <= state_q inside {HSMWS_HALL, HSMWS_CONV};
      adc_start <= state_q == HSMWS_CONV && !conv_q && !restart; // R15
      mux_sel <= ch_q; // R5
      cycle_busy <= state_q != HSMWS_LOWPWR;
    end
  end

  // capture results and window compare per axis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_x <= '0;
      result_y <= '0;
      result_z <= '0;
      result_t <= '0;
      oow_q <= 3'h0;
    end else if (state_q == HSMWS_BIAS) begin
      oow_q <= 3'h0;
    end else if (state_q == HSMWS_CONV && conv_q && done_evt) begin
      unique case (ch_q)
        CH_X: begin
          result_x <= adc_data;
          oow_q[0] <= adc_data > thr_hi_x_q || adc_data < thr_lo_x_q; // R7
        end
        CH_Y: begin
          result_y <= adc_data;
          oow_q[1] <= adc_data > thr_hi_y_q || adc_data < thr_lo_y_q; // R7
        end
        CH_Z: begin
          result_z <= adc_data;
          oow_q[2] <= adc_data > thr_hi_z_q || adc_data < thr_lo_z_q; // R7
        end
        CH_T: result_t <= adc_data;
      endcase
    end
  end

  assign oow_now = |oow_q; // R11

  // wake request raised at cycle end; held while the bus is busy and collision avoidance is on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wake_pend_q <= 1'b0;
    else if (state_q == HSMWS_DONE && oow_now) wake_pend_q <= 1'b1; // R8 R9
    else if (wake_q) wake_pend_q <= 1'b0;
  end

  // fixed length active-low pulse; collision avoidance defers its start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= '0;
      wake_q <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      if (pulse_q != '0) pulse_q <= pulse_q - 1'b1; // R16
      else if (wake_pend_q && !(ca_s2_q && busy_s2_q)) begin // R10
        pulse_q <= CNT_W'(INT_PULSE_CYC);
        wake_q <= 1'b1;
      end
    end
  end

  // open drain: only ever pulls low, released otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_n_o <= 1'b0;
      int_n_oe <= 1'b0;
    end else begin
      int_n_o <= 1'b0; // R12
      int_n_oe <= pulse_q != '0; // R12 R16
    end
  end
endmodule

/* File: test/hsmws_properties.sv */
/* checker for the measurement sequencer and wake-up interrupt.
 * assumes it is bound onto hsmws_top and sees only its ports. */
`timescale 1ns/1ps
module hsmws_properties
  import hsmws_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_busy,
  input wire logic temp_en,
  input wire logic coll_avoid_en,
  input wire logic supply_ok,
  input wire logic bias_en,
  input wire logic osc_en,
  input wire logic hall_bias_en,
  input wire logic adc_start,
  input wire logic [1:0] mux_sel,
  input wire logic cycle_busy,
  input wire logic int_n_o,
  input wire logic int_n_oe
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_int_len;
    $rose(int_n_oe) |-> int_n_oe [*8] ##1 !int_n_oe;
  endproperty
  a_int_len: assert property (p_int_len)
    else $error("pulse length wrong");
  property p_int_od;
    int_n_oe |-> int_n_o == 1'b0;
  endproperty
  a_int_od: assert property (p_int_od)
    else $error("pin not pulled low");
  // sync delay on the busy line is why five cycles are needed
  property p_coll;
    (coll_avoid_en && link_busy) [*5] |-> !$rose(int_n_oe);
  endproperty
  a_coll: assert property (p_coll)
    else $error("pulse during bus activity");
  property p_start;
    adc_start |=> !adc_start [*3];
  endproperty
  a_start: assert property (p_start)
    else $error("start too long");
  property p_order;
    $changed(mux_sel) && mux_sel != CH_X |-> mux_sel == $past(mux_sel) + 2'h1;
  endproperty
  a_order: assert property (p_order)
    else $error("channel order");
  property p_temp;
    adc_start && mux_sel == CH_T |-> temp_en;
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature while off");
  property p_supply;
    !supply_ok [*5] |-> !adc_start;
  endproperty
  a_supply: assert property (p_supply)
    else $error("conversion on low supply");
  property p_steps;
    adc_start |-> hall_bias_en && osc_en && bias_en && cycle_busy;
  endproperty
  a_steps: assert property (p_steps)
    else $error("conversion without bias");
  c_int: cover property ($rose(int_n_oe));
  c_temp: cover property (adc_start && mux_sel == CH_T);
  c_coll: cover property (coll_avoid_en && link_busy && cycle_busy);
endmodule

/* File: test/hsmws_master_model.sv */
/* i2c master stand-in giving config strobes and bus activity.
 * assumes the bench owns link_clk and toggles cfg_req per write. */
`timescale 1ns/1ps
module hsmws_master_model (
  input wire logic link_clk,
  input wire logic cfg_req,
  input wire logic busy_req,
  output logic link_cfg_wr,
  output logic link_busy
);
  logic r1 = 1'b0;
  logic r2 = 1'b0;
  logic r3 = 1'b0;
  // the toggle comes from the core clock, so resync it first
  always_ff @(posedge link_clk) begin
    r1 <= cfg_req;
    r2 <= r1;
    r3 <= r2;
  end
  // only the master starts writes: one link cycle per config
  assign link_cfg_wr = r2 ^ r3;
  assign link_busy = busy_req | link_cfg_wr;
endmodule

/* File: test/tb_top.sv */
/* bench for hsmws_top with converter stand-in and master model.
 * assumes the checker file and master model are compiled first. */
`timescale 1ns/1ps
module tb_top;
  import hsmws_pkg::*;
  logic clk, nrst, link_clk, temp_en, coll_avoid_en, supply_ok, adc_done;
  logic cfg_req, busy_req, link_cfg_wr, link_busy, int_d;
  logic bias_en, osc_en, hall_bias_en, adc_start, cycle_busy;
  logic int_n_o, int_n_oe;
  logic [1:0] mux_sel;
  logic [DATA_W-1:0] adc_data, b, hi[3], lo[3], vals[4], res[4];
  int num_errors, samples_checked, n_int, n_seen, cyc, dcnt, n_start, s0;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #24 link_clk = ~link_clk;
  end
  hsmws_master_model mst_u (.link_clk, .cfg_req, .busy_req, .link_cfg_wr,
    .link_busy);
  hsmws_top dut_u (.clk, .nrst, .link_clk, .link_cfg_wr, .link_busy,
    .temp_en, .coll_avoid_en, .supply_ok, .thr_hi_x(hi[0]),
    .thr_hi_y(hi[1]), .thr_hi_z(hi[2]), .thr_lo_x(lo[0]), .thr_lo_y(lo[1]),
    .thr_lo_z(lo[2]), .adc_done, .adc_data, .bias_en, .osc_en,
    .hall_bias_en, .adc_start, .mux_sel, .result_x(res[0]),
    .result_y(res[1]), .result_z(res[2]), .result_t(res[3]), .cycle_busy,
    .int_n_o, .int_n_oe);
  // converter: done held two cycles so each start gives a fresh edge
  always @(posedge clk) begin
    if (adc_start === 1'b1) begin
      adc_data <= vals[mux_sel];
      adc_done <= 1'b1;
      dcnt <= 2;
      n_start <= n_start + 1;
    end else if (dcnt > 1) begin
      dcnt <= dcnt - 1;
    end else begin
      adc_done <= 1'b0;
    end
  end
  // count interrupt pulses and cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    int_d <= int_n_oe;
    if (int_n_oe === 1'b1 && int_d !== 1'b1) n_int <= n_int + 1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run;
    end
  end
  task chk(input string s, input logic [DATA_W-1:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task chk_irq(input logic [DATA_W-1:0] e);
    chk("irq_count", e, DATA_W'(n_int - n_seen));
    n_seen = n_int;
  endtask
  task wait_v(input logic v);
    while (cycle_busy !== v) @(posedge clk);
  endtask
  task run;
    cfg_req <= ~cfg_req;
    wait_v(1'b1);
    wait_v(1'b0);
    repeat (40) @(posedge clk);
  endtask
  task complete_run;
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence; window edges equal the thresholds on purpose
  initial begin
    nrst = 1'b0;
    temp_en = 1'b1;
    coll_avoid_en = 1'b0;
    supply_ok = 1'b1;
    cfg_req = 1'b0;
    busy_req = 1'b0;
    adc_done = 1'b0;
    adc_data = 12'h000;
    hi = '{12'h800, 12'h900, 12'hA00};
    lo = '{12'h400, 12'h300, 12'h200};
    vals = '{12'h800, 12'h300, 12'h500, 12'h123};
    repeat (20) @(posedge clk);
    chk("bias_en", 12'h001, DATA_W'(bias_en));
    chk("osc_en", 12'h001, DATA_W'(osc_en));
    nrst <= 1'b1;
    repeat (20) @(posedge clk);
    chk("bias_en_idle", 12'h000, DATA_W'(bias_en));
    chk("osc_en_idle", 12'h000, DATA_W'(osc_en));
    run;
    for (int i = 0; i < 4; i++) chk("result", vals[i], res[i]);
    chk_irq(12'h000);
    for (int a = 0; a < 6; a++) begin
      b = vals[a % 3];
      vals[a % 3] = (a < 3) ? hi[a] + 12'h001 : lo[a - 3] - 12'h001;
      run;
      chk_irq(12'h001);
      vals[a % 3] = b;
    end
    temp_en <= 1'b0;
    vals[3] = 12'h456;
    run;
    chk("result_t", 12'h123, res[3]);
    temp_en <= 1'b1;
    coll_avoid_en <= 1'b1;
    busy_req <= 1'b1;
    vals[2] = 12'hA01;
    run;
    chk_irq(12'h000);
    busy_req <= 1'b0;
    repeat (60) @(posedge clk);
    chk_irq(12'h001);
    coll_avoid_en <= 1'b0;
    vals[2] = 12'h500;
    vals[0] = 12'h7FF;
    s0 = n_start;
    cfg_req <= ~cfg_req;
    while (adc_start !== 1'b1) @(posedge clk);
    supply_ok <= 1'b0;
    repeat (30) @(posedge clk);
    supply_ok <= 1'b1;
    wait_v(1'b0);
    repeat (40) @(posedge clk);
    for (int i = 0; i < 4; i++) chk("result", vals[i], res[i]);
    chk("restart_starts", 12'h005, DATA_W'(n_start - s0));
    chk_irq(12'h000);
    // a second config lands mid-cycle: exactly one more cycle follows
    s0 = n_start;
    cfg_req <= ~cfg_req;
    wait_v(1'b1);
    cfg_req <= ~cfg_req;
    wait_v(1'b0);
    wait_v(1'b1);
    wait_v(1'b0);
    repeat (40) @(posedge clk);
    chk("pended_starts", 12'h008, DATA_W'(n_start - s0));
    complete_run;
  end
endmodule
bind hsmws_top hsmws_properties prop_u (.clk, .nrst, .link_busy, .temp_en,
  .coll_avoid_en, .supply_ok, .bias_en, .osc_en, .hall_bias_en, .adc_start,
  .mux_sel, .cycle_busy, .int_n_o, .int_n_oe);
